// ==== rtl/bvsp_defs.vh ====
// constants of the time-slotted voice serial port
`ifndef BVSP_DEFS_VH
`define BVSP_DEFS_VH

// port modes
`define BVSP_MODE_NB 2'h0
`define BVSP_MODE_WIDE 2'h1
`define BVSP_MODE_SUBBAND 2'h2
`define BVSP_MODE_BTFM 2'h3

// fill of the three spare narrowband bits
`define BVSP_FILL_ZERO 2'h0
`define BVSP_FILL_ONE 2'h1
`define BVSP_FILL_SIGN 2'h2
`define BVSP_FILL_PROG 2'h3

// frame geometry
`define BVSP_WORD_BITS 16
`define BVSP_MAX_RATE_SEL 3'h4
`define BVSP_BTFM_LAST 8'h2F
`define BVSP_LONG_SYNC_BITS 8'h03
`define BVSP_REP_8K 3'h5
`define BVSP_REP_16K 3'h2

// bit clock high/low least times, and the system clock period
`define BVSP_SYS_CLK_PS 5000
`define BVSP_NORM_HALF_PS 41000
`define BVSP_BURST_HALF_PS 20800
`define BVSP_NORM_HALF_CYC \
  ((`BVSP_NORM_HALF_PS + `BVSP_SYS_CLK_PS - 1) / `BVSP_SYS_CLK_PS)
`define BVSP_BURST_HALF_CYC \
  ((`BVSP_BURST_HALF_PS + `BVSP_SYS_CLK_PS - 1) / `BVSP_SYS_CLK_PS)

// shadow configuration word: field lsb positions
`define BVSP_CFG_W 41
`define BVSP_CF_MASTER 40
`define BVSP_CF_LONG 39
`define BVSP_CF_RATE 36
`define BVSP_CF_FS16 35
`define BVSP_CF_MODE 33
`define BVSP_CF_BURST 32
`define BVSP_CF_DIV 22
`define BVSP_CF_CHEN 19
`define BVSP_CF_S0 15
`define BVSP_CF_S1 11
`define BVSP_CF_S2 7
`define BVSP_CF_RJ 6
`define BVSP_CF_LSBF 5
`define BVSP_CF_FILL 3
`define BVSP_CF_FVAL 0
// slave, short sync, one slot, narrowband, left, msb first
`define BVSP_CFG_RST 41'h000C3080000

`endif

// ==== rtl/bvsp_slot_mem.v ====
// sixteen-word transmit sample store, one word per slot
`timescale 1ns/1ps
module bvsp_slot_mem (
  // clock
  input wire sys_clk,
  // write side
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [15:0] wr_data,
  // read side
  input wire [3:0] rd_addr,
  output reg [15:0] rd_data
);

  reg [15:0] mem [0:15];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // bvsp_slot_mem

// ==== rtl/bvsp_voice_port.v ====
// time-slotted voice serial port engine, master or slave
//
// Operation
// - two ports exist; each instance yields its shared pins to I2S.
// - master drives bit clock and sync; slave takes both as inputs.
// - host configuration arrives as ports, taken while the port halts.
// - up to three full-duplex channels share one port by slots.
// - a frame holds at most sixteen slots at 8 or 16 kHz.
// - outside combined mode, slot count per frame follows the selected port rate.
// - a channel's transmit and receive use the same slot.
// - serial out is released during unused slots.
// - serial out releases after falling edge in slot's last bit.
// - short sync: one bit wide high pulse, launched on rising edge.
// - slave samples short sync on falling edge; slot 0 follows.
// - long sync: three bits high, starting with slot zero bit.
// - narrowband uses 13 of 16 bits, position and order selectable.
// - spare bits ignored in; sent as zeros, ones, sign or value.
// - reset format: 13-bit, left justified, msb first.
// - wideband transparent carries raw 16-bit words.
// - subband codec mode carries linear 16-bit samples.
// - combined mode: three 16-bit channels, BT, FM left, FM right.
// - combined mode repeats BT sample six or three times.
// - several BT streams in combined mode need port master.
// - mode changes only after halt and restart.
// - burst mode permits bit clock up to 20 MHz (five-cycle half period).
`timescale 1ns/1ps
`include "bvsp_defs.vh"
module bvsp_voice_port (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // control
  input wire run_en,
  input wire i2s_own,
  // configuration, taken while halted
  input wire cfg_master,
  input wire cfg_long_sync,
  input wire [2:0] cfg_rate_sel,
  input wire cfg_fs16,
  input wire [1:0] cfg_mode,
  input wire cfg_burst,
  input wire [9:0] cfg_half_div,
  input wire [2:0] cfg_ch_en,
  input wire [3:0] cfg_ch0_slot,
  input wire [3:0] cfg_ch1_slot,
  input wire [3:0] cfg_ch2_slot,
  input wire cfg_right_just,
  input wire cfg_lsb_first,
  input wire [1:0] cfg_fill_sel,
  input wire [2:0] cfg_fill_val,
  // transmit samples
  input wire tx_wr,
  input wire [3:0] tx_wr_slot,
  input wire [15:0] tx_wr_data,
  // receive samples
  output reg rx_valid,
  output reg [3:0] rx_slot,
  output reg [15:0] rx_data,
  // status
  output wire port_running,
  output reg frame_start,
  output wire cfg_error,
  // bit clock pin
  input wire bclk_i,
  output wire bclk_o,
  output wire bclk_oe,
  // frame sync pin
  input wire sync_i,
  output reg sync_o,
  output wire sync_oe,
  // serial data pins
  input wire sdin_i,
  output reg sdout_o,
  output reg sdout_oe
);

  localparam ST_IDLE = 3'b001;
  localparam ST_HUNT = 3'b010;
  localparam ST_RUN = 3'b100;

  localparam integer NORM_HALF_I = `BVSP_NORM_HALF_CYC;
  localparam integer BURST_HALF_I = `BVSP_BURST_HALF_CYC;
  localparam [9:0] NORM_HALF = NORM_HALF_I[9:0];
  localparam [9:0] BURST_HALF = BURST_HALF_I[9:0];

  function [15:0] bit_rev;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        bit_rev[i] = v[15 - i];
      end
    end
  endfunction

  function [15:0] fmt_tx;
    input [15:0] s;
    input [1:0] mode;
    input rj;
    input lsbf;
    input [1:0] fsel;
    input [2:0] fval;
    reg [2:0] fill;
    reg [15:0] w;
    begin
      fill = 3'h0;
      w = s;
      if (mode == `BVSP_MODE_NB) begin
        case (fsel)
          `BVSP_FILL_ONE: fill = 3'h7;
          `BVSP_FILL_SIGN: fill = {3{s[12]}};
          `BVSP_FILL_PROG: fill = fval;
          default: fill = 3'h0;
        endcase
        w = rj ? {fill, s[12:0]} : {s[12:0], fill};
      end
      fmt_tx = lsbf ? bit_rev(w) : w;
    end
  endfunction

  function [15:0] fmt_rx;
    input [15:0] w;
    input [1:0] mode;
    input rj;
    input lsbf;
    reg [15:0] v;
    reg [12:0] t;
    begin
      v = lsbf ? bit_rev(w) : w;
      t = rj ? v[12:0] : v[15:3];
      // spare bits dropped, sample sign extended
      fmt_rx = (mode == `BVSP_MODE_NB) ? {{3{t[12]}}, t} : v;
    end
  endfunction

  // configuration shadow
  reg [`BVSP_CFG_W-1:0] cfg_q;
  reg [2:0] st_q;
  wire [`BVSP_CFG_W-1:0] cfg_d;
  assign cfg_d = {cfg_master, cfg_long_sync, cfg_rate_sel, cfg_fs16,
                  cfg_mode, cfg_burst, cfg_half_div, cfg_ch_en,
                  cfg_ch0_slot, cfg_ch1_slot, cfg_ch2_slot,
                  cfg_right_just, cfg_lsb_first, cfg_fill_sel,
                  cfg_fill_val};

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_q <= `BVSP_CFG_RST;
    end else if (st_q == ST_IDLE) begin
      cfg_q <= cfg_d;
    end
  end

  wire c_master = cfg_q[`BVSP_CF_MASTER];
  wire c_long = cfg_q[`BVSP_CF_LONG];
  wire [2:0] c_rate = cfg_q[`BVSP_CF_RATE+2:`BVSP_CF_RATE];
  wire c_fs16 = cfg_q[`BVSP_CF_FS16];
  wire [1:0] c_mode = cfg_q[`BVSP_CF_MODE+1:`BVSP_CF_MODE];
  wire c_burst = cfg_q[`BVSP_CF_BURST];
  wire [9:0] c_div = cfg_q[`BVSP_CF_DIV+9:`BVSP_CF_DIV];
  wire [2:0] c_chen = cfg_q[`BVSP_CF_CHEN+2:`BVSP_CF_CHEN];
  wire [3:0] c_s0 = cfg_q[`BVSP_CF_S0+3:`BVSP_CF_S0];
  wire [3:0] c_s1 = cfg_q[`BVSP_CF_S1+3:`BVSP_CF_S1];
  wire [3:0] c_s2 = cfg_q[`BVSP_CF_S2+3:`BVSP_CF_S2];
  wire c_rj = cfg_q[`BVSP_CF_RJ];
  wire c_lsbf = cfg_q[`BVSP_CF_LSBF];
  wire [1:0] c_fill = cfg_q[`BVSP_CF_FILL+1:`BVSP_CF_FILL];
  wire [2:0] c_fval = cfg_q[`BVSP_CF_FVAL+2:`BVSP_CF_FVAL];
  wire c_btfm = (c_mode == `BVSP_MODE_BTFM);

  // a slave in combined mode carries only the first BT stream
  wire fm_slave_multi = c_btfm && !c_master && (|c_chen[2:1]);
  wire rate_bad = (c_rate > `BVSP_MAX_RATE_SEL);
  assign cfg_error = fm_slave_multi || rate_bad;
  wire [2:0] ch_en = fm_slave_multi ? {2'h0, c_chen[0]} : c_chen;
  wire [2:0] rate = rate_bad ? `BVSP_MAX_RATE_SEL : c_rate;

  // last bit index of the frame
  wire [8:0] frame_bits = 9'h010 << rate;
  wire [7:0] last_idx = c_btfm ? `BVSP_BTFM_LAST :
                        frame_bits[7:0] - 8'h01;

  function slot_used;
    input [3:0] sl;
    input fm;
    input [2:0] en;
    input [3:0] a;
    input [3:0] b;
    input [3:0] c;
    begin
      if (fm) begin
        slot_used = (sl == 4'h0) ? en[0] : (sl < 4'h3);
      end else begin
        slot_used = (en[0] && sl == a) || (en[1] && sl == b) ||
                    (en[2] && sl == c);
      end
    end
  endfunction

  // pin synchronisers
  reg bclk_s1_q, bclk_s2_q, sync_s1_q, sync_s2_q, sdin_s1_q, sdin_s2_q;
  always @(posedge sys_clk) begin
    bclk_s1_q <= bclk_i;
    bclk_s2_q <= bclk_s1_q;
    sync_s1_q <= sync_i;
    sync_s2_q <= sync_s1_q;
    sdin_s1_q <= sdin_i;
    sdin_s2_q <= sdin_s1_q;
  end

  // master bit clock divider
  wire [9:0] half_min = c_burst ? BURST_HALF : NORM_HALF;
  wire [9:0] half = (c_div < half_min) ? half_min : c_div;
  reg [9:0] hc_q;
  reg bclk_q;
  wire drive_link = c_master && !i2s_own && st_q != ST_IDLE;
  always @(posedge sys_clk) begin
    if (sys_rst || !drive_link) begin
      hc_q <= 10'h000;
      bclk_q <= 1'b0;
    end else if (hc_q >= half - 10'h001) begin
      hc_q <= 10'h000;
      bclk_q <= !bclk_q;
    end else begin
      hc_q <= hc_q + 10'h001;
    end
  end

  assign bclk_o = bclk_q;
  assign bclk_oe = drive_link;
  assign sync_oe = drive_link;
  assign port_running = (st_q == ST_RUN);

  // edges of the bit clock in use
  reg bc_prev_q;
  wire bc = c_master ? bclk_q : bclk_s2_q;
  wire rise = bc && !bc_prev_q;
  wire fall = !bc && bc_prev_q;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bc_prev_q <= 1'b0;
    end else begin
      bc_prev_q <= bc;
    end
  end

  // frame position
  reg [7:0] idx_q;
  reg pend_q;
  reg sync_prev_q;
  reg [2:0] rep_q;
  reg [15:0] tsh_q;
  reg [15:0] rsh_q;
  reg [15:0] bt_hold_q;
  reg [3:0] rd_addr_q;
  wire [15:0] mem_rd;

  wire short_hit = !c_master && !c_long && sync_s2_q;
  wire long_hit = !c_master && c_long && sync_s2_q && !sync_prev_q;
  wire [7:0] idx_inc = (idx_q == last_idx) ? 8'h00 : idx_q + 8'h01;
  wire [7:0] nidx = pend_q ? 8'h00 : idx_inc;
  wire n_used = slot_used(nidx[7:4], c_btfm, ch_en, c_s0, c_s1, c_s2);
  wire c_used = slot_used(idx_q[7:4], c_btfm, ch_en, c_s0, c_s1, c_s2);
  wire bt_repeat = c_btfm && (rep_q != 3'h0);
  wire [2:0] rep_last = c_fs16 ? `BVSP_REP_16K : `BVSP_REP_8K;
  wire [15:0] tx_word = (bt_repeat && nidx[7:4] == 4'h0) ? bt_hold_q :
                        mem_rd;
  wire [15:0] tx_fmt = fmt_tx(tx_word, c_mode, c_rj, c_lsbf, c_fill, c_fval);
  wire [15:0] rx_word = {rsh_q[14:0], sdin_s2_q};

  // run state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (run_en && !i2s_own) begin
            st_q <= cfg_master ? ST_RUN : ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (!run_en || i2s_own) begin
            st_q <= ST_IDLE;
          end else if (fall && (short_hit || long_hit)) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_en || i2s_own) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // link side datapath
  always @(posedge sys_clk) begin
    if (sys_rst || st_q == ST_IDLE) begin
      idx_q <= last_idx;
      pend_q <= c_master;
      sync_prev_q <= 1'b0;
      rep_q <= 3'h0;
      tsh_q <= 16'h0000;
      rsh_q <= 16'h0000;
      bt_hold_q <= 16'h0000;
      rd_addr_q <= 4'h0;
      sync_o <= 1'b0;
      sdout_o <= 1'b0;
      sdout_oe <= 1'b0;
      rx_valid <= 1'b0;
      rx_slot <= 4'h0;
      rx_data <= 16'h0000;
      frame_start <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      frame_start <= 1'b0;
      if (rise && st_q == ST_RUN) begin
        idx_q <= nidx;
        pend_q <= 1'b0;
        // short sync leads slot zero by one bit
        if (c_long) begin
          sync_o <= (nidx < `BVSP_LONG_SYNC_BITS);
        end else begin
          sync_o <= (nidx == last_idx);
        end
        if (nidx == 8'h00) begin
          frame_start <= 1'b1;
          rep_q <= (!c_btfm || rep_q == rep_last) ? 3'h0 :
                   rep_q + 3'h1;
        end
        if (!n_used) begin
          sdout_oe <= 1'b0;
        end else if (nidx[3:0] == 4'h0) begin
          tsh_q <= tx_fmt;
          sdout_o <= tx_fmt[15];
          sdout_oe <= !i2s_own;
          if (c_btfm && nidx[7:4] == 4'h0 && !bt_repeat) begin
            bt_hold_q <= mem_rd;
          end
        end else begin
          tsh_q <= {tsh_q[14:0], 1'b0};
          sdout_o <= tsh_q[14];
        end
      end else if (fall) begin
        sync_prev_q <= sync_s2_q;
        if (short_hit) begin
          pend_q <= 1'b1;
        end
        if (long_hit) begin
          // this bit is slot zero's first; the next rise moves on
          idx_q <= 8'h00;
        end
        // fetch ahead for the next slot; data held at least 5 cycles
        rd_addr_q <= short_hit ? 4'h0 : idx_inc[7:4];
        if (st_q == ST_RUN && c_used) begin
          rsh_q <= rx_word;
          if (idx_q[3:0] == 4'hF) begin
            sdout_oe <= 1'b0;
            if (!(bt_repeat && idx_q[7:4] == 4'h0)) begin
              rx_valid <= 1'b1;
              rx_slot <= idx_q[7:4];
              rx_data <= fmt_rx(rx_word, c_mode, c_rj, c_lsbf);
            end
          end
        end
      end
    end
  end

  bvsp_slot_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(tx_wr),
    .wr_addr(tx_wr_slot),
    .wr_data(tx_wr_data),
    .rd_addr(rd_addr_q),
    .rd_data(mem_rd)
  );

endmodule // bvsp_voice_port

// ==== testbench/bvsp_monitor.sv ====
// assertion checker bound to the voice slot serial port
`timescale 1ns/1ps
module bvsp_monitor (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // control
  input wire run_en,
  input wire i2s_own,
  // status
  input wire port_running,
  input wire frame_start,
  input wire rx_valid,
  // pins
  input wire bclk_o,
  input wire bclk_oe,
  input wire sync_o,
  input wire sync_oe,
  input wire sdout_o,
  input wire sdout_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_pins_to_i2s: assert property (i2s_own |-> !bclk_oe && !sync_oe)
    else $error("port drives pins owned by i2s");
  a_clk_sync_oe: assert property (bclk_oe == sync_oe)
    else $error("clock and sync enables differ");
  a_halt_quiet: assert property (!run_en [*3] |->
    !port_running && !sdout_oe && !bclk_oe)
    else $error("port active while halted");
  // halt cuts a half period short, so it is excluded
  a_bclk_min_half: assert property (disable iff (sys_rst || !run_en ||
    i2s_own) bclk_oe && $changed(bclk_o) |=> $stable(bclk_o) [*4])
    else $error("bit clock half period below five cycles");
  a_data_launch: assert property (disable iff (sys_rst || !run_en)
    sdout_oe && bclk_oe && $changed(sdout_o) |->
    $past(bclk_o) && !$past(bclk_o, 2))
    else $error("data launched off the rising edge");
  a_sync_launch: assert property (disable iff (sys_rst || !run_en)
    sync_oe && $changed(sync_o) |-> $past(bclk_o) && !$past(bclk_o, 2))
    else $error("sync launched off the rising edge");
  a_frame_on_rise: assert property (frame_start && bclk_oe |->
    $past(bclk_o) && !$past(bclk_o, 2))
    else $error("frame start not on a rising edge");
  a_rx_released: assert property (rx_valid |-> !sdout_oe)
    else $error("data still driven after slot end");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive strobe longer than one cycle");
endmodule // bvsp_monitor

bind bvsp_voice_port bvsp_monitor i_bvsp_monitor (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .run_en(run_en), .i2s_own(i2s_own),
  .port_running(port_running), .frame_start(frame_start),
  .rx_valid(rx_valid), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .sync_o(sync_o),
  .sync_oe(sync_oe), .sdout_o(sdout_o), .sdout_oe(sdout_oe));

// ==== testbench/bvsp_codec_model.sv ====
// behavioural codec that masters bit clock and sync in slave runs
`timescale 1ns/1ps
module bvsp_codec_model (
  // control
  input wire en,
  input wire long_sync,
  input wire [15:0] tx_word,
  // line from the port
  input wire sd_line,
  // lines to the port
  output reg bclk,
  output reg sync,
  output reg sdin,
  // word captured in the last frame
  output reg [15:0] rx_word
);
  integer k;
  reg [15:0] acc;
  initial begin
    bclk = 1'b0;
    sync = 1'b0;
    sdin = 1'b0;
    rx_word = 16'h0000;
    acc = 16'h0000;
    forever begin
      if (!en) begin
        // clock stands still; idle data keeps moving so no stale bit passes
        sync = 1'b0;
        #62.5 sdin = ~sdin;
      end else begin
        for (k = 0; k < 16; k = k + 1) begin
          bclk = 1'b1;
          sync = long_sync ? (k < 3) : (k == 15);
          sdin = tx_word[15-k];
          #62.5 bclk = 1'b0;
          acc[15-k] = sd_line;
          if (k == 15) rx_word = acc;
          #62.5;
        end
      end
    end
  end
endmodule // bvsp_codec_model

// ==== testbench/test_bvsp_voice_port.sv ====
// self-checking bench of the voice slot serial port
`timescale 1ns/1ps
module test_bvsp_voice_port;
  reg sys_clk = 1'b0, sys_rst = 1'b1, run_en = 1'b0, i2s_own = 1'b0;
  reg cfg_master = 1'b0, cfg_long_sync = 1'b0, cfg_fs16 = 1'b0;
  reg cfg_burst = 1'b0, cfg_right_just = 1'b0, cfg_lsb_first = 1'b0;
  reg [2:0] cfg_rate_sel = 3'h0, cfg_ch_en = 3'h1, cfg_fill_val = 3'h5;
  reg [1:0] cfg_mode = 2'h0, cfg_fill_sel = 2'h0;
  reg [9:0] cfg_half_div = 10'h009;
  reg tx_wr = 1'b0, sd_last = 1'b0;
  reg [15:0] tx_wr_data = 16'h0000, c_tx = 16'hA5C3;
  wire rx_valid, port_running, frame_start, cfg_error, bclk_o, bclk_oe;
  wire sync_o, sync_oe, sdout_o, sdout_oe, c_bclk, c_sync, c_sdin;
  wire [3:0] rx_slot;
  wire [15:0] rx_data, c_rx;
  wire sd_line = sdout_oe ? sdout_o : ~sd_last;
  integer error_cnt = 0, num_checks = 0, n, i;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sdout_oe) sd_last <= sdout_o;
  bvsp_voice_port i_bvsp_voice_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .run_en(run_en), .i2s_own(i2s_own), .cfg_master(cfg_master),
    .cfg_long_sync(cfg_long_sync), .cfg_rate_sel(cfg_rate_sel),
    .cfg_fs16(cfg_fs16), .cfg_mode(cfg_mode), .cfg_burst(cfg_burst),
    .cfg_half_div(cfg_half_div), .cfg_ch_en(cfg_ch_en),
    .cfg_ch0_slot(4'h0), .cfg_ch1_slot(4'h1), .cfg_ch2_slot(4'h2),
    .cfg_right_just(cfg_right_just), .cfg_lsb_first(cfg_lsb_first),
    .cfg_fill_sel(cfg_fill_sel), .cfg_fill_val(cfg_fill_val),
    .tx_wr(tx_wr), .tx_wr_slot(4'h0), .tx_wr_data(tx_wr_data),
    .rx_valid(rx_valid), .rx_slot(rx_slot), .rx_data(rx_data),
    .port_running(port_running), .frame_start(frame_start),
    .cfg_error(cfg_error), .bclk_i(bclk_oe ? bclk_o : c_bclk),
    .bclk_o(bclk_o), .bclk_oe(bclk_oe), .sync_i(sync_oe ? sync_o : c_sync),
    .sync_o(sync_o), .sync_oe(sync_oe), .sdin_i(c_sdin), .sdout_o(sdout_o),
    .sdout_oe(sdout_oe));
  bvsp_codec_model i_bvsp_codec_model (.en(run_en & ~cfg_master),
    .long_sync(cfg_long_sync), .tx_word(c_tx), .sd_line(sd_line),
    .bclk(c_bclk), .sync(c_sync), .sdin(c_sdin), .rx_word(c_rx));

  task close_out;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // bounded wait for frame_start (sel 1) or rx_valid (sel 0)
  task wait_ev(input sel);
    begin
      n = 0;
      tick;
      while (!(sel ? frame_start : rx_valid) && n < 6000) begin
        tick;
        n = n + 1;
      end
      if (n >= 6000) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t event wait ran out", $time);
        close_out;
      end
    end
  endtask
  // configuration only lands while halted
  task halt;
    begin
      run_en = 1'b0;
      repeat (3) tick;
    end
  endtask
  task start;
    begin
      repeat (2) tick;
      run_en = 1'b1;
    end
  endtask
  task wr_tx(input [15:0] d);
    begin
      tx_wr = 1'b1;
      tx_wr_data = d;
      tick;
      tx_wr = 1'b0;
      tick;
    end
  endtask
  function [15:0] rev16(input [15:0] w);
    integer j;
    begin
      for (j = 0; j < 16; j = j + 1) rev16[j] = w[15-j];
    end
  endfunction
  // second frame is judged; the first may follow the hunt for sync
  task slave_run(input [15:0] exp_rx, input [15:0] exp_tx);
    begin
      start;
      wait_ev(1'b0);
      wait_ev(1'b0);
      cmp(rx_data, exp_rx);
      cmp(c_rx, exp_tx);
      cmp({12'h0, rx_slot}, 16'h0000);
      halt;
    end
  endtask
  task t_fill;
    reg [12:0] s;
    reg [2:0] f;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        s = (i == 2) ? 13'h1A5B : 13'h0A5B;
        f = (i == 0) ? 3'h0 : (i == 3) ? 3'h5 : 3'h7;
        wr_tx({3'h0, s});
        cfg_fill_sel = i[1:0];
        slave_run({{3{c_tx[15]}}, c_tx[15:3]}, {s, f});
      end
      cfg_fill_sel = 2'h0;
    end
  endtask
  task t_format;
    reg [15:0] r;
    begin
      wr_tx(16'h0A5B);
      cfg_right_just = 1'b1;
      slave_run({{3{c_tx[12]}}, c_tx[12:0]}, 16'h0A5B);
      cfg_right_just = 1'b0;
      cfg_lsb_first = 1'b1;
      r = rev16(c_tx);
      slave_run({{3{r[15]}}, r[15:3]}, rev16(16'h52D8));
      cfg_lsb_first = 1'b0;
    end
  endtask
  task t_wide;
    begin
      wr_tx(16'hC0DE);
      for (i = 1; i < 3; i = i + 1) begin
        cfg_mode = i[1:0];
        slave_run(c_tx, 16'hC0DE);
      end
      cfg_mode = 2'h0;
    end
  endtask
  // master frame length and sync width, in system clock cycles
  task m_case(input [2:0] r, input b, input [9:0] d, input l,
    input [1:0] m, input [15:0] per, input [15:0] sw);
    integer c, h;
    begin
      cfg_master = 1'b1;
      cfg_rate_sel = r;
      cfg_burst = b;
      cfg_half_div = d;
      cfg_long_sync = l;
      cfg_mode = m;
      start;
      wait_ev(1'b1);
      c = 0;
      h = 0;
      do begin
        if (sync_o) h = h + 1;
        c = c + 1;
        tick;
      end while (!frame_start && c < 6000);
      cmp(c[15:0], per);
      cmp(h[15:0], sw);
      cmp({14'h0, bclk_oe, sync_oe}, 16'h0003);
      halt;
      cfg_master = 1'b0;
      cfg_long_sync = 1'b0;
    end
  endtask
  task t_master;
    begin
      m_case(3'h0, 1'b0, 10'h009, 1'b0, 2'h0, 16'h0120, 16'h0012);
      m_case(3'h1, 1'b0, 10'h005, 1'b0, 2'h0, 16'h0240, 16'h0012);
      m_case(3'h2, 1'b1, 10'h005, 1'b1, 2'h0, 16'h0280, 16'h001E);
      m_case(3'h4, 1'b0, 10'h009, 1'b0, 2'h0, 16'h1200, 16'h0012);
      m_case(3'h0, 1'b0, 10'h009, 1'b0, 2'h3, 16'h0360, 16'h0012);
      cfg_rate_sel = 3'h0;
      cfg_burst = 1'b0;
      cfg_mode = 2'h0;
    end
  endtask
  task t_i2s;
    begin
      cfg_master = 1'b1;
      start;
      wait_ev(1'b1);
      i2s_own = 1'b1;
      repeat (3) tick;
      cmp({12'h0, bclk_oe, sync_oe, sdout_oe, port_running}, 16'h0000);
      i2s_own = 1'b0;
      halt;
      cfg_master = 1'b0;
    end
  endtask
  task t_cfg_err;
    begin
      cfg_rate_sel = 3'h5;
      repeat (2) tick;
      cmp({15'h0, cfg_error}, 16'h0001);
      cfg_rate_sel = 3'h0;
      cfg_mode = 2'h3;
      cfg_ch_en = 3'h3;
      repeat (2) tick;
      cmp({15'h0, cfg_error}, 16'h0001);
      cfg_ch_en = 3'h1;
      repeat (2) tick;
      cmp({15'h0, cfg_error}, 16'h0000);
      cfg_mode = 2'h0;
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    tick;
    cmp({13'h0, port_running, bclk_oe, sdout_oe}, 16'h0000);
    t_fill;
    t_format;
    t_wide;
    t_master;
    t_i2s;
    t_cfg_err;
    close_out;
  end
endmodule // test_bvsp_voice_port
